// ### tir_defs.svh
`ifndef TIR_DEFS_SVH
`define TIR_DEFS_SVH

// ----------------------------------------
// Register byte addresses (index times four)
// ----------------------------------------
`define TIR_IDX_ROUTE 8'h0d
`define TIR_ADDR_ROUTE 8'h34
`define TIR_ADDR_THRESH 8'h80
`define TIR_ADDR_STAT 8'h84
`define TIR_ADDR_EN 8'h88
`define TIR_ADDR_CLR 8'h8c
`define TIR_ADDR_W 8

// ----------------------------------------
// Route config field layout
// ----------------------------------------
`define TIR_A_SEL_HI 7
`define TIR_A_SEL_LO 6
`define TIR_B_SEL_HI 5
`define TIR_B_SEL_LO 4
`define TIR_B_TX_BIT 3
`define TIR_FULL_BIT 2
`define TIR_NEMPTY_BIT 1
`define TIR_OVR_BIT 0
`define TIR_ROUTE_RST 5'h00

// ----------------------------------------
// Threshold and status
// ----------------------------------------
`define TIR_THRESH_W 6
`define TIR_THRESH_RST 6'h0f
`define TIR_LEVEL_W 7
`define TIR_DEPTH 7'h40
`define TIR_NEV 4
`define TIR_EV_OVR 0
`define TIR_EV_THR 1
`define TIR_EV_TXD 2
`define TIR_EV_PLR 3

// ----------------------------------------
// Selector codes and AHB encodings
// ----------------------------------------
`define TIR_SEL_00 2'h0
`define TIR_SEL_01 2'h1
`define TIR_SEL_10 2'h2
`define TIR_SEL_11 2'h3
`define TIR_HTRANS_NSEQ_BIT 1
`define TIR_ZERO32 32'h0000_0000

`endif

// ### tir_pkg.sv
package tir_pkg;

	// Data mode as seen on data_mode_select
	typedef enum logic [1:0] {
		TIR_DM_CONT = 2'h0,
		TIR_DM_BUF = 2'h1,
		TIR_DM_PKT0 = 2'h2,
		TIR_DM_PKT1 = 2'h3
	} tir_dmode_e;

	// Radio operating state, one-hot
	typedef enum logic [3:0] {
		TIR_RS_SLEEP = 4'h1,
		TIR_RS_STBY = 4'h2,
		TIR_RS_RX = 4'h4,
		TIR_RS_TX = 4'h8
	} tir_rstate_e;

	// Internal event sources
	typedef struct packed {
		logic sync_detect;
		logic address_match;
		logic addr_filter_en;
		logic rssi_event;
		logic byte_written;
		logic payload_ready;
		logic crc_pass;
		logic transmit_complete;
		logic recovered_data_clock;
	} tir_events_s;

	// Routing selectors
	typedef struct packed {
		logic [1:0] int_a_rx_select;
		logic [1:0] int_b_rx_select;
		logic int_b_tx_select;
	} tir_route_s;

	// FIFO status into the router
	typedef struct packed {
		logic full;
		logic nonempty;
		logic at_thresh;
	} tir_fifo_s;

endpackage

// ### tir_route_mux.sv
`timescale 1ns/1ps
`include "tir_defs.svh"

module tir_route_mux import tir_pkg::*; (
	// Mode
	input wire tir_dmode_e dmode,
	input wire tir_rstate_e rstate,
	// Sources
	input wire tir_route_s route,
	input wire tir_events_s ev,
	input wire tir_fifo_s fifo,
	// Routed lines
	output logic line_a,
	output logic line_b
);

	logic a_rx;
	logic b_rx;
	logic b_tx;
	logic sync_or_adr;

	assign sync_or_adr = ev.addr_filter_en ? ev.address_match
		: ev.sync_detect; // RL3

	always_comb begin
		a_rx = 1'b0;
		case (route.int_a_rx_select)
		`TIR_SEL_11: a_rx = (dmode[1]) ? sync_or_adr : ev.sync_detect;
		`TIR_SEL_10: a_rx = (dmode == TIR_DM_CONT) ? ev.sync_detect
			: ~fifo.nonempty; // RL2 RL7
		`TIR_SEL_01: a_rx = (dmode == TIR_DM_CONT) ? ev.rssi_event
			: ev.byte_written; // RL1
		`TIR_SEL_00: begin
			if (dmode == TIR_DM_CONT)
				a_rx = ev.sync_detect; // RL1
			else if (dmode == TIR_DM_BUF)
				a_rx = 1'b0; // RL14
			else
				a_rx = ev.payload_ready; // RL3
		end
		default: a_rx = 1'b0;
		endcase
	end

	always_comb begin
		b_rx = 1'b0;
		if (dmode == TIR_DM_CONT) begin
			b_rx = ev.recovered_data_clock; // RL4
		end else begin
			case (route.int_b_rx_select)
			`TIR_SEL_11: b_rx = fifo.at_thresh; // RL5 RL6 RL7
			`TIR_SEL_10: b_rx = ev.rssi_event; // RL5
			`TIR_SEL_01: b_rx = fifo.full; // RL5 RL7
			`TIR_SEL_00: b_rx = dmode[1] & ev.crc_pass; // RL6 RL14
			default: b_rx = 1'b0;
			endcase
		end
	end

	// Transmit routing of line b
	always_comb begin
		if (dmode == TIR_DM_CONT)
			b_tx = ev.recovered_data_clock; // RL8
		else if (route.int_b_tx_select)
			b_tx = ev.transmit_complete; // RL8
		else
			b_tx = fifo.full; // RL8
	end

	always_comb begin
		line_a = 1'b0;
		line_b = 1'b0;
		case (rstate)
		TIR_RS_RX, TIR_RS_STBY: begin
			line_a = a_rx;
			line_b = b_rx;
		end
		TIR_RS_TX: begin
			line_b = b_tx;
		end
		TIR_RS_SLEEP: begin
			line_a = 1'b0;
			line_b = 1'b0;
		end
		default: begin
			line_a = 1'b0;
			line_b = 1'b0;
		end
		endcase
	end

endmodule

// ### tir_irq_route.sv
// How it works
// RL1: Continuous mode rx/standby: line a is sync, or signal strength on code 01.
// RL2: Buffer mode line a: 11 sync, 10 FIFO empty, 01 byte written, 00 none.
// RL3: Packet line a: 11 sync/address match, 10 empty, 01 byte, 00 payload.
// RL4: Continuous mode rx/standby: line b carries recovered data clock.
// RL5: Buffer line b: 11 threshold, 10 signal strength, 01 full, 00 none.
// RL6: Packet line b: 11 threshold, 10 signal strength, 01 full, 00 CRC.
// RL7: FIFO empty, full and threshold sources also work in standby.
// RL8: Transmit line b: data clock, else transmit-complete or FIFO full.
// RL9: Route register bit 2 reads 1 while FIFO is full.
// RL10: Route register bit 1 reads 1 while FIFO holds data.
// RL11: Route register bit 0 goes 1 on FIFO overrun.
// RL12: Host writing 1 to bit 0 clears overrun and flushes FIFO.
// RL13: Threshold source compares fill level with six-bit field, reset 001111.
// RL14: Overrun stays set until cleared; no-source codes keep line low.
// RL15: Data mode and radio state come in from mode control.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "tir_defs.svh"

module tir_irq_route import tir_pkg::*; #(
	parameter logic [`TIR_LEVEL_W-1:0] FIFO_DEPTH = `TIR_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Mode control
	input wire tir_dmode_e data_mode_select,
	input wire tir_rstate_e radio_state,
	// Event sources
	input wire tir_events_s events,
	// FIFO side
	input wire logic [`TIR_LEVEL_W-1:0] buffer_level,
	input wire logic buffer_overrun_event,
	output logic buffer_flush,
	// Host lines
	output logic int_out_a,
	output logic int_out_b,
	output logic irq
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	tir_route_s route_r;
	logic overrun_r;
	logic [`TIR_THRESH_W-1:0] thresh_r;
	logic [`TIR_NEV-1:0] stat_r;
	logic [`TIR_NEV-1:0] en_r;
	logic full_r;
	logic nonempty_r;
	logic at_thresh_r;

	// ----------------------------------------
	// AHB address phase capture
	// ----------------------------------------
	logic ap_valid;
	logic wr_pend_r;
	logic [`TIR_ADDR_W-1:0] wr_addr_r;
	logic [31:0] rd_data_nxt;

	assign ap_valid = hsel & hready & htrans[`TIR_HTRANS_NSEQ_BIT];

	// Only the word-aligned low byte of the address is decoded
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
		end else if (hready) begin
			wr_pend_r <= ap_valid & hwrite;
			wr_addr_r <= haddr[`TIR_ADDR_W-1:0];
		end
	end

	// Zero wait states: every register answers in its data phase
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hreadyout <= 1'b1;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	// No register can refuse, so the response is always OKAY
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------
	// Write decode (data phase)
	// ----------------------------------------
	logic wr_route;
	logic wr_thresh;
	logic wr_en;
	logic wr_clr;
	logic ovr_clear;

	assign wr_route = wr_pend_r & (wr_addr_r == `TIR_ADDR_ROUTE);
	assign wr_thresh = wr_pend_r & (wr_addr_r == `TIR_ADDR_THRESH);
	assign wr_en = wr_pend_r & (wr_addr_r == `TIR_ADDR_EN);
	assign wr_clr = wr_pend_r & (wr_addr_r == `TIR_ADDR_CLR);
	assign ovr_clear = wr_route & hwdata[`TIR_OVR_BIT]; // RL12

	// ----------------------------------------
	// Route configuration
	// ----------------------------------------
	// Bits 2..0 are not stored here; reads show the live flags
	always_ff @(posedge clk) begin
		if (!resetn) begin
			route_r <= `TIR_ROUTE_RST;
		end else if (wr_route) begin
			route_r.int_a_rx_select <=
				hwdata[`TIR_A_SEL_HI:`TIR_A_SEL_LO];
			route_r.int_b_rx_select <=
				hwdata[`TIR_B_SEL_HI:`TIR_B_SEL_LO];
			route_r.int_b_tx_select <= hwdata[`TIR_B_TX_BIT];
		end
	end

	// ----------------------------------------
	// Threshold
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			thresh_r <= `TIR_THRESH_RST; // RL13
		end else if (wr_thresh) begin
			thresh_r <= hwdata[`TIR_THRESH_W-1:0];
		end
	end

	// ----------------------------------------
	// FIFO status
	// ----------------------------------------
	// Status is registered so reads and routing see one aligned view
	always_ff @(posedge clk) begin
		if (!resetn) begin
			full_r <= 1'b0;
		end else begin
			full_r <= (buffer_level >= FIFO_DEPTH); // RL9
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			nonempty_r <= 1'b0;
		end else begin
			nonempty_r <= (buffer_level != '0); // RL10
		end
	end

	// Strictly above: a level equal to the threshold does not fire
	always_ff @(posedge clk) begin
		if (!resetn) begin
			at_thresh_r <= 1'b0;
		end else begin
			at_thresh_r <= (buffer_level >
				{1'b0, thresh_r}); // RL13
		end
	end

	// ----------------------------------------
	// Overrun flag and flush
	// ----------------------------------------
	// A new overrun in the clearing cycle wins and keeps the flag set
	always_ff @(posedge clk) begin
		if (!resetn) begin
			overrun_r <= 1'b0;
		end else if (buffer_overrun_event) begin
			overrun_r <= 1'b1; // RL11
		end else if (ovr_clear) begin
			overrun_r <= 1'b0; // RL12 RL14
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			buffer_flush <= 1'b0;
		end else begin
			buffer_flush <= ovr_clear; // RL12
		end
	end

	// ----------------------------------------
	// Routing
	// ----------------------------------------
	tir_fifo_s fifo_st;
	logic line_a;
	logic line_b;

	assign fifo_st.full = full_r;
	assign fifo_st.nonempty = nonempty_r;
	assign fifo_st.at_thresh = at_thresh_r;

	tir_route_mux u_mux (
		.dmode(data_mode_select), // RL15
		.rstate(radio_state), // RL15
		.route(route_r),
		.ev(events),
		.fifo(fifo_st),
		.line_a(line_a),
		.line_b(line_b)
	);

	// One flop of latency on both lines keeps them glitch-free
	always_ff @(posedge clk) begin
		if (!resetn) begin
			int_out_a <= 1'b0;
		end else begin
			int_out_a <= line_a; // RL1 RL2 RL3
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			int_out_b <= 1'b0;
		end else begin
			int_out_b <= line_b; // RL4 RL5 RL6 RL8
		end
	end

	// ----------------------------------------
	// Interrupt status, enable, clear
	// ----------------------------------------
	logic [`TIR_NEV-1:0] ev_now;
	logic [`TIR_NEV-1:0] ev_prev_r;
	logic [`TIR_NEV-1:0] ev_rise;

	// Edges only: a level held high is recorded once
	assign ev_now[`TIR_EV_OVR] = overrun_r;
	assign ev_now[`TIR_EV_THR] = at_thresh_r;
	assign ev_now[`TIR_EV_TXD] = events.transmit_complete;
	assign ev_now[`TIR_EV_PLR] = events.payload_ready;
	assign ev_rise = ev_now & ~ev_prev_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ev_prev_r <= '0;
		end else begin
			ev_prev_r <= ev_now;
		end
	end

	// Per-bit sticky status; a rising event beats a clear
	genvar gi;
	generate
		for (gi = 0; gi < `TIR_NEV; gi++) begin : g_stat
			always_ff @(posedge clk) begin
				if (!resetn) begin
					stat_r[gi] <= 1'b0;
				end else if (ev_rise[gi]) begin
					stat_r[gi] <= 1'b1;
				end else if (wr_clr & hwdata[gi]) begin
					stat_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Enable gates only the output; status still records masked events
	always_ff @(posedge clk) begin
		if (!resetn) begin
			en_r <= '0;
		end else if (wr_en) begin
			en_r <= hwdata[`TIR_NEV-1:0];
		end
	end

	// Level output follows status one cycle late
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_r & en_r);
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Each word is built on its own so the address decode stays flat
	logic [31:0] route_word;
	logic [31:0] thresh_word;
	logic [31:0] stat_word;
	logic [31:0] en_word;

	always_comb begin
		route_word = `TIR_ZERO32;
		route_word[`TIR_A_SEL_HI:`TIR_A_SEL_LO] =
			route_r.int_a_rx_select;
		route_word[`TIR_B_SEL_HI:`TIR_B_SEL_LO] =
			route_r.int_b_rx_select;
		route_word[`TIR_B_TX_BIT] = route_r.int_b_tx_select;
		route_word[`TIR_FULL_BIT] = full_r; // RL9
		route_word[`TIR_NEMPTY_BIT] = nonempty_r; // RL10
		route_word[`TIR_OVR_BIT] = overrun_r; // RL11
	end

	always_comb begin
		thresh_word = `TIR_ZERO32;
		thresh_word[`TIR_THRESH_W-1:0] = thresh_r;
	end

	always_comb begin
		stat_word = `TIR_ZERO32;
		stat_word[`TIR_NEV-1:0] = stat_r;
	end

	always_comb begin
		en_word = `TIR_ZERO32;
		en_word[`TIR_NEV-1:0] = en_r;
	end

	always_comb begin
		case (haddr[`TIR_ADDR_W-1:0])
		`TIR_ADDR_ROUTE: rd_data_nxt = route_word;
		`TIR_ADDR_THRESH: rd_data_nxt = thresh_word;
		`TIR_ADDR_STAT: rd_data_nxt = stat_word;
		`TIR_ADDR_EN: rd_data_nxt = en_word;
		default: rd_data_nxt = `TIR_ZERO32;
		endcase
	end

	// Read data sampled at address phase, presented in data phase
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hrdata <= `TIR_ZERO32;
		end else if (ap_valid & ~hwrite) begin
			hrdata <= rd_data_nxt;
		end
	end

endmodule

// ### tir_irq_route_props.sv
`timescale 1ns/1ps

module tir_irq_route_props import tir_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Mode and lines
	input wire tir_dmode_e data_mode_select,
	input wire tir_rstate_e radio_state,
	input wire tir_events_s events,
	input wire logic buffer_flush,
	input wire logic int_out_a,
	input wire logic int_out_b,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	logic take;
	logic rt;
	assign take = hsel && hready && htrans[1];
	assign rt = take && haddr[7:0] == 8'h34;

	flush_on_one_a: assert property (
		rt && hwrite ##1 hwdata[0] |=> buffer_flush) else $error("no flush");
	no_flush_zero_a: assert property (
		rt && hwrite ##1 !hwdata[0] |=> !buffer_flush) else $error("bad flush");
	okay_resp_a: assert property (
		hresp == 1'b0 && hreadyout) else $error("bus not okay");
	route_upper_a: assert property (
		rt && !hwrite |=> hrdata[31:8] == 24'h0) else $error("upper bits");
	sleep_quiet_a: assert property (
		radio_state == TIR_RS_SLEEP |=> !int_out_a && !int_out_b)
		else $error("sleep lines");
	tx_a_quiet_a: assert property (
		radio_state == TIR_RS_TX |=> !int_out_a) else $error("tx line a");
	cont_clock_b_a: assert property (
		data_mode_select == TIR_DM_CONT &&
		(radio_state == TIR_RS_RX || radio_state == TIR_RS_STBY)
		|=> int_out_b == $past(events.recovered_data_clock))
		else $error("rx clock line");
	tx_clock_b_a: assert property (
		data_mode_select == TIR_DM_CONT && radio_state == TIR_RS_TX
		|=> int_out_b == $past(events.recovered_data_clock))
		else $error("tx clock line");

	cover property (buffer_flush);
	cover property ($rose(int_out_a));
	cover property ($rose(irq));
endmodule

bind tir_irq_route tir_irq_route_props tir_irq_route_props_i (
	.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.data_mode_select(data_mode_select), .radio_state(radio_state),
	.events(events), .buffer_flush(buffer_flush), .int_out_a(int_out_a),
	.int_out_b(int_out_b), .irq(irq)
);

// ### tir_fifo_model.sv
`timescale 1ns/1ps

module tir_fifo_model #(
	parameter logic [6:0] DEPTH = 7'h40
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Writer and flush
	input wire logic push,
	input wire logic flush,
	// Status
	output logic [6:0] level,
	output logic overrun
);
	always_ff @(posedge clk) begin
		if (!resetn || flush) begin
			level <= 7'h00;
		end else if (push && level < DEPTH) begin
			level <= level + 7'h01;
		end
	end

	// Write into a full store is lost, so it is reported
	always_ff @(posedge clk) begin
		overrun <= resetn && push && level == DEPTH;
	end
endmodule

// ### tir_irq_route_test.sv
`timescale 1ns/1ps

module tir_irq_route_test import tir_pkg::*; ;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic push = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, q;
	logic [1:0] htrans = 2'h0;
	tir_dmode_e dm = TIR_DM_CONT;
	tir_rstate_e rs = TIR_RS_STBY;
	tir_events_s ev = '0;
	logic hreadyout, hresp, flush, ovr, int_a, int_b, irq;
	logic [6:0] level;
	logic exp_a, exp_b;
	int bad_count = 0;
	int checks = 0;

	always #25 clk = ~clk;

	tir_irq_route tir_irq_route_i (.clk(clk), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .data_mode_select(dm),
		.radio_state(rs), .events(ev), .buffer_level(level),
		.buffer_overrun_event(ovr), .buffer_flush(flush),
		.int_out_a(int_a), .int_out_b(int_b), .irq(irq));
	tir_fifo_model tir_fifo_model_i (.clk(clk), .resetn(resetn),
		.push(push), .flush(flush), .level(level), .overrun(ovr));

	// ----------------------------------------
	// Bus and check helpers
	// ----------------------------------------
	task end_sim;
		$display("mismatches %0d of %0d checks", bad_count, checks);
		if (bad_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask

	task rdy;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (hreadyout === 1'b1) return;
		end
		bad_count++;
		end_sim;
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		q = hrdata;
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	function logic ref_a(tir_dmode_e m, logic [1:0] c, tir_events_s e);
		logic s;
		s = (m[1] && e.addr_filter_en) ? e.address_match : e.sync_detect;
		case (c)
			2'h3: ref_a = s;
			2'h2: ref_a = m == TIR_DM_CONT ? e.sync_detect : 1'b1;
			2'h1: ref_a = m == TIR_DM_CONT ? e.rssi_event : e.byte_written;
			default: ref_a = m == TIR_DM_CONT ? e.sync_detect :
				m[1] & e.payload_ready;
		endcase
	endfunction

	function logic ref_b(tir_dmode_e m, logic t, logic [1:0] c,
		tir_events_s e);
		if (m == TIR_DM_CONT) return e.recovered_data_clock;
		if (t) return c[0] & e.transmit_complete;
		case (c)
			2'h2: ref_b = e.rssi_event;
			2'h0: ref_b = m[1] & e.crc_pass;
			default: ref_b = 1'b0;
		endcase
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		bus(0, 8'h34, 0);
		chk("route", q, 32'h0);
		bus(0, 8'h80, 0);
		chk("thresh", q, 32'h0f);
		bus(1, 8'h80, 32'hc5);
		bus(0, 8'h80, 0);
		chk("thresh rw", q, 32'h05);
		bus(1, 8'h80, 32'h0f);
		bus(0, 8'h10, 0);
		chk("unmapped", q, 32'h0);
		bus(1, 8'h34, 32'hff);
		bus(0, 8'h34, 0);
		chk("route ro", q, 32'hf8);
		$display("test regs done");
	endtask

	task t_route;
		for (int s = 0; s < 4; s++) begin
			for (int m = 0; m < 4; m++) begin
				for (int c = 0; c < 4; c++) begin
					rs <= tir_rstate_e'(4'h1 << s);
					dm <= tir_dmode_e'(m[1:0]);
					bus(1, 8'h34, {24'h0, c[1:0], c[1:0], c[0], 3'h0});
					for (int k = 0; k < 11; k++) begin
						ev <= tir_events_s'(k < 9 ? 9'h1 << k :
							(k == 9 ? 9'h0c0 : 9'h140));
						tick(3);
						exp_a = (s == 0 || s == 3) ? 1'b0 :
							ref_a(dm, c[1:0], ev);
						exp_b = (s == 0) ? 1'b0 :
							ref_b(dm, s == 3, c[1:0], ev);
						chk("line a", int_a, exp_a);
						chk("line b", int_b, exp_b);
					end
				end
			end
		end
		$display("test route done");
	endtask

	task t_fifo;
		ev <= '0;
		rs <= TIR_RS_STBY;
		dm <= TIR_DM_BUF;
		bus(1, 8'h34, 32'hb0);
		push <= 1'b1;
		tick(15);
		push <= 1'b0;
		tick(3);
		chk("thr edge", int_b, 1'b0);
		push <= 1'b1;
		tick(1);
		push <= 1'b0;
		tick(3);
		chk("thr line", int_b, 1'b1);
		chk("empty line", int_a, 1'b0);
		push <= 1'b1;
		tick(48);
		push <= 1'b0;
		bus(1, 8'h34, 32'h90);
		tick(2);
		chk("full line", int_b, 1'b1);
		rs <= TIR_RS_TX;
		tick(2);
		chk("tx full line", int_b, 1'b1);
		rs <= TIR_RS_STBY;
		bus(0, 8'h34, 0);
		chk("full bits", q, 32'h96);
		push <= 1'b1;
		tick(1);
		push <= 1'b0;
		tick(3);
		bus(0, 8'h34, 0);
		chk("overrun", q, 32'h97);
		tick(10);
		bus(1, 8'h34, 32'h90);
		bus(0, 8'h34, 0);
		chk("overrun held", q, 32'h97);
		bus(1, 8'h34, 32'h91);
		tick(3);
		bus(0, 8'h34, 0);
		chk("cleared", q, 32'h90);
		$display("test fifo done");
	endtask

	task t_irq;
		bus(1, 8'h8c, 32'hf);
		bus(1, 8'h88, 32'h4);
		ev <= tir_events_s'(9'h002);
		tick(4);
		chk("irq set", irq, 1'b1);
		bus(0, 8'h84, 0);
		chk("status", q, 32'h4);
		bus(1, 8'h8c, 32'h4);
		tick(3);
		chk("irq clear", irq, 1'b0);
		bus(1, 8'h88, 32'h0);
		ev <= '0;
		tick(2);
		ev <= tir_events_s'(9'h002);
		tick(4);
		chk("irq mask", irq, 1'b0);
		bus(0, 8'h84, 0);
		chk("status mask", q, 32'h4);
		$display("test irq done");
	endtask

	initial begin
		tick(2);
		resetn <= 1'b1;
		tick(1);
		t_regs;
		t_route;
		t_fifo;
		t_irq;
		end_sim;
	end
endmodule
